// ===== qpf_pkg.sv
// Shared constants, enumerations and carrier types of the quad phase fetch pipeline
`default_nettype none

package qpf_pkg;

  // Widths of the program and data paths
  localparam int unsigned PC_W        = 11;
  localparam int unsigned INSTR_W     = 12;
  localparam int unsigned FADDR_W     = 7;
  localparam int unsigned FILE_OFF_W  = 5;
  localparam int unsigned JUMP_TGT_W  = 9;
  localparam int unsigned PHASE_COUNT = 4;

  // Program memory map
  localparam logic [10:0] RESET_VECTOR     = 11'h3ff;
  localparam logic [10:0] USER_FIRST       = 11'h000;
  localparam logic [10:0] USER_LAST        = 11'h3ff;
  localparam logic [10:0] FLASH_DATA_FIRST = 11'h400;
  localparam logic [10:0] FLASH_DATA_LAST  = 11'h43f;
  localparam logic [10:0] CFG_FIRST        = 11'h440;
  localparam logic [10:0] USER_ID_LAST     = 11'h443;
  localparam logic [10:0] CAL_FIRST        = 11'h444;
  localparam logic [10:0] CAL_LAST         = 11'h447;
  localparam logic [10:0] RSV_FIRST        = 11'h448;
  localparam logic [10:0] RSV_LAST         = 11'h49f;
  localparam logic [10:0] CFG_WORD_ADDR    = 11'h7ff;
  localparam int unsigned PAGE_WORDS       = 512;
  localparam int unsigned PAGE_BIT_POS     = 9;

  // Data register file
  localparam int unsigned SFR_COUNT     = 13;
  localparam int unsigned GPR_COUNT     = 41;
  localparam int unsigned BANK_WORDS    = 32;
  localparam int unsigned FSP_BANK_HI   = 6;
  localparam int unsigned FSP_BANK_LO   = 5;
  localparam logic [4:0]  SFR_LAST_OFF  = 5'h0c;
  localparam logic [4:0]  SHARED_FIRST  = 5'h0d;
  localparam logic [4:0]  SHARED_LAST   = 5'h0f;
  localparam logic [6:0]  BANK0_BASE    = 7'h00;
  localparam logic [6:0]  BANK1_BASE    = 7'h20;
  localparam logic [6:0]  BANK2_BASE    = 7'h40;
  localparam logic [6:0]  BANK3_BASE    = 7'h60;

  // Instruction phases, one per input clock
  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR  = 2'b11
  } qpf_phase_t;

  // Program address regions
  typedef enum logic [2:0] {
    RG_USER       = 3'b000,
    RG_FLASH_DATA = 3'b001,
    RG_USER_ID    = 3'b010,
    RG_CAL_BACKUP = 3'b011,
    RG_RESERVED   = 3'b100,
    RG_CFG_WORD   = 3'b101,
    RG_CFG_OTHER  = 3'b110
  } qpf_region_t;

  // One-hot phase strobes
  typedef struct packed {
    logic one;
    logic two;
    logic three;
    logic four;
  } qpf_phases_t;

  // Branch request from the execute logic
  typedef struct packed {
    logic                  req;
    logic [JUMP_TGT_W-1:0] target;
  } qpf_branch_t;

  // Data register file access
  typedef struct packed {
    logic               rdEn;
    logic               wrEn;
    logic [FADDR_W-1:0] addr;
    logic               special_function_register;
  } qpf_dmem_t;

  // Program memory fetch request
  typedef struct packed {
    logic            rdEn;
    logic [PC_W-1:0] addr;
    qpf_region_t     region;
    logic            writable;
  } qpf_fetch_t;

endpackage

`default_nettype wire

// ===== qpf_phase_gen.sv
// Four phase generator that divides the input clock into instruction phases
`timescale 1ns/1ns
`default_nettype none

module qpf_phase_gen (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            clkEn,
  output qpf_pkg::qpf_phase_t  phase,
  output qpf_pkg::qpf_phases_t strobes
);
  import qpf_pkg::*;

  typedef struct packed {
    qpf_phase_t phase;
  } qpf_gen_state_t;

  qpf_gen_state_t s_q;
  qpf_gen_state_t s_d;

  // Step one phase per enabled clock, wrapping after phase four
  always_comb begin
    s_d = s_q;
    if (clkEn) begin
      unique case (s_q.phase)
        PH_ONE:   s_d.phase = PH_TWO; // RULE1
        PH_TWO:   s_d.phase = PH_THREE;
        PH_THREE: s_d.phase = PH_FOUR;
        PH_FOUR:  s_d.phase = PH_ONE;
      endcase
    end
  end

  // Restart at phase one on reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{phase: PH_ONE};
    end else begin
      s_q <= s_d;
    end
  end

  // Non-overlapping strobes decoded from the phase register
  assign phase         = s_q.phase;
  assign strobes.one   = (s_q.phase == PH_ONE);
  assign strobes.two   = (s_q.phase == PH_TWO);
  assign strobes.three = (s_q.phase == PH_THREE);
  assign strobes.four  = (s_q.phase == PH_FOUR);

endmodule

`default_nettype wire

// ===== qpf_fetch_pipeline.sv
// Two-stage fetch and execute sequencer with program and data memory decoding
`timescale 1ns/1ns
`default_nettype none

// Contract
// RULE1 - The input clock is divided by four into four non-overlapping phases that together form one instruction cycle.
// RULE2 - The program counter advances in phase one and the addressed word is fetched by the end of phase four.
// RULE3 - The fetched word enters the instruction holding register in phase one and is executed over phases two to four.
// RULE4 - The data operand is read in phase two and the result is written in phase four.
// RULE5 - Fetch of the next word overlaps execution of the current one so plain instructions retire one per cycle.
// RULE6 - A change of program counter discards the word already fetched, so a branch costs two cycles.
// RULE7 - The program counter is 11 bits wide and addresses 2K words of 12 bits.
// RULE8 - User code lives at 0x000 to 0x3FF and the reset vector is 0x3FF.
// RULE9 - The self-writable data flash block sits at 0x400 to 0x43F and is treated as ordinary program flash.
// RULE10 - Addresses 0x440 to 0x7FF are configuration space with the configuration word at 0x7FF.
// RULE11 - User identification words sit at 0x440 to 0x443 and calibration backups at 0x444 to 0x447.
// RULE12 - Addresses 0x448 to 0x49F are reserved and carry no user or identification content.
// RULE13 - The data register file holds 13 special function registers and 41 general purpose registers.
// RULE14 - Data banks are selected by bits of the file select pointer because the file exceeds 32 registers.
// RULE15 - Program pages are selected by one status bit because program memory exceeds 512 words.
// RULE16 - File select pointer bits six and five pick one of four banks based at 00h, 20h, 40h and 60h.
// RULE17 - Reset restarts at phase one with an empty pipeline so the reset vector word executes first.
module qpf_fetch_pipeline (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic                           clkEn,
  input  wire logic [qpf_pkg::INSTR_W-1:0]    progData,
  input  wire logic                           pageSel,
  input  wire logic [7:0]                     fileSelect,
  input  wire qpf_pkg::qpf_branch_t           branch,
  input  wire logic                           execWrReq,
  output qpf_pkg::qpf_fetch_t                 fetch,
  output logic [qpf_pkg::INSTR_W-1:0]         instrHold,
  output logic                                instrValid,
  output qpf_pkg::qpf_phases_t                phases,
  output qpf_pkg::qpf_dmem_t                  dmem
);
  import qpf_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0]    pc;
    logic [PC_W-1:0]    fetchAddr;
    logic [INSTR_W-1:0] fetched;
    logic               fetchedValid;
    logic [INSTR_W-1:0] ir;
    logic               irValid;
    logic [FADDR_W-1:0] dAddr;
    logic               dSfr;
  } qpf_state_t;

  qpf_state_t s_q;
  qpf_state_t s_d;
  qpf_phase_t phase;

  // Next user address; the reset vector rolls over to the start of user space
  function automatic logic [PC_W-1:0] pcNext(input logic [PC_W-1:0] pc);
    if (pc == USER_LAST) begin
      return USER_FIRST; // RULE8
    end
    return pc + 11'h001; // RULE7
  endfunction

  // Region of a program address
  function automatic qpf_region_t regionOf(input logic [PC_W-1:0] a);
    if (a <= USER_LAST) begin
      return RG_USER; // RULE8
    end else if (a <= FLASH_DATA_LAST) begin
      return RG_FLASH_DATA; // RULE9
    end else if (a <= USER_ID_LAST) begin
      return RG_USER_ID; // RULE11
    end else if (a >= CAL_FIRST && a <= CAL_LAST) begin
      return RG_CAL_BACKUP; // RULE11
    end else if (a >= RSV_FIRST && a <= RSV_LAST) begin
      return RG_RESERVED; // RULE12
    end else if (a == CFG_WORD_ADDR) begin
      return RG_CFG_WORD; // RULE10
    end
    return RG_CFG_OTHER; // RULE10
  endfunction

  // Full file address from pointer bank bits and a five bit offset
  function automatic logic [FADDR_W-1:0] bankMap(input logic [7:0] fsp, input logic [4:0] off);
    logic [FADDR_W-1:0] base;
    base = BANK0_BASE;
    unique case (fsp[FSP_BANK_HI:FSP_BANK_LO]) // RULE14
      2'b00: base = BANK0_BASE; // RULE16
      2'b01: base = BANK1_BASE;
      2'b10: base = BANK2_BASE;
      2'b11: base = BANK3_BASE;
    endcase
    if (off >= SHARED_FIRST && off <= SHARED_LAST) begin
      base = BANK0_BASE; // Shared words fold back into bank zero
    end
    return base | {2'b00, off};
  endfunction

  // Special function registers occupy the low offsets of each bank
  function automatic logic isSfr(input logic [4:0] off);
    return off <= SFR_LAST_OFF; // RULE13
  endfunction

  // Phase generator
  qpf_phase_gen u_phase (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .phase   (phase),
    .strobes (phases)
  );

  // Pipeline sequencing across the four phases
  always_comb begin
    s_d = s_q;
    if (clkEn) begin
      unique case (phase)
        PH_ONE: begin
          s_d.ir           = s_q.fetched; // RULE3
          s_d.irValid      = s_q.fetchedValid; // RULE5
          s_d.fetchAddr    = s_q.pc; // RULE2
          s_d.pc           = pcNext(s_q.pc); // RULE2
          s_d.fetchedValid = 1'b0;
          s_d.dAddr        = bankMap(fileSelect, s_q.fetched[FILE_OFF_W-1:0]);
          s_d.dSfr         = isSfr(s_q.fetched[FILE_OFF_W-1:0]);
        end
        PH_TWO, PH_THREE: begin
        end
        PH_FOUR: begin
          s_d.fetched      = progData; // RULE2
          s_d.fetchedValid = 1'b1; // RULE5
          if (s_q.irValid && branch.req) begin
            s_d.pc           = {1'b0, pageSel, branch.target}; // RULE15
            s_d.fetchedValid = 1'b0; // RULE6
          end
        end
      endcase
    end
  end

  // State register; reset empties the pipeline and points at the reset vector
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{pc: RESET_VECTOR, fetchAddr: RESET_VECTOR, fetched: '0, fetchedValid: 1'b0,
               ir: '0, irValid: 1'b0, dAddr: '0, dSfr: 1'b0}; // RULE17
    end else begin
      s_q <= s_d;
    end
  end

  // Program memory request, held from phase two through phase four
  assign fetch.rdEn     = (phase != PH_ONE); // RULE2
  assign fetch.addr     = s_q.fetchAddr;
  assign fetch.region   = regionOf(s_q.fetchAddr);
  assign fetch.writable = (regionOf(s_q.fetchAddr) == RG_USER) ||
                          (regionOf(s_q.fetchAddr) == RG_FLASH_DATA); // RULE9

  // Executing instruction and data memory strobes
  assign instrHold  = s_q.ir;
  assign instrValid = s_q.irValid;
  assign dmem.rdEn  = clkEn && (phase == PH_TWO) && s_q.irValid; // RULE4
  assign dmem.wrEn  = clkEn && (phase == PH_FOUR) && s_q.irValid && execWrReq; // RULE4
  assign dmem.addr  = s_q.dAddr;
  assign dmem.special_function_register   = s_q.dSfr;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_phase_walk_order: assert property ( // RULE1
    clkEn && phase == PH_ONE ##1 clkEn [*3] |-> phases.four && $past(phases.three) && $past(phases.two, 2))
    else $error("phases did not step one to four");

  chk_phase_one_hot: assert property ( // RULE1
    $onehot({phases.one, phases.two, phases.three, phases.four}))
    else $error("phase strobes overlap");

  chk_pc_advance_one: assert property ( // RULE2
    clkEn && phase == PH_ONE |=> s_q.pc == pcNext($past(s_q.pc)) && s_q.fetchAddr == $past(s_q.pc))
    else $error("program counter did not advance in phase one");

  chk_pc_hold_other: assert property ( // RULE2
    phase == PH_TWO || phase == PH_THREE || !clkEn |=> $stable(s_q.pc))
    else $error("program counter moved outside phase one and four");

  chk_fetch_latch_four: assert property ( // RULE2
    clkEn && phase == PH_FOUR && !(s_q.irValid && branch.req) |=> s_q.fetched == $past(progData) && s_q.fetchedValid)
    else $error("fetched word not latched in phase four");

  chk_ir_load_one: assert property ( // RULE3
    clkEn && phase == PH_ONE |=> instrHold == $past(s_q.fetched) && instrValid == $past(s_q.fetchedValid))
    else $error("holding register not loaded in phase one");

  chk_dmem_read_two: assert property ( // RULE4
    dmem.rdEn |-> phase == PH_TWO && instrValid)
    else $error("data read outside phase two");

  chk_dmem_write_four: assert property ( // RULE4
    dmem.wrEn |-> phase == PH_FOUR && instrValid && execWrReq)
    else $error("data write outside phase four");

  chk_branch_flush_cycle: assert property ( // RULE6
    clkEn && phase == PH_FOUR && instrValid && branch.req ##1 (clkEn && phase == PH_ONE)
      |=> !instrValid && s_q.fetchAddr == {1'b0, $past(pageSel, 2), $past(branch.target, 2)})
    else $error("branch did not flush and fetch target");

  chk_user_rollover: assert property ( // RULE8
    clkEn && phase == PH_ONE && s_q.pc == USER_LAST |=> s_q.pc == USER_FIRST)
    else $error("reset vector did not roll to user start");

  chk_bank_select_map: assert property ( // RULE16
    clkEn && phase == PH_ONE && s_q.fetched[4:0] > SHARED_LAST
      |=> dmem.addr[6:5] == $past(fileSelect[6:5]) && dmem.addr[4:0] == $past(s_q.fetched[4:0]))
    else $error("bank bits not taken from file select pointer");

  // A low enable freezes every register of the pipeline and the phase
  chk_freeze_all_state: assert property (
    !clkEn |=> $stable(s_q) && $stable(phase))
    else $error("state moved while clock enable was low");

  // First edge after reset still points at the reset vector with nothing to execute
  chk_reset_vector_first: assert property ( // RULE17
    $fell(rst) |-> fetch.addr == RESET_VECTOR && !instrValid)
    else $error("pipeline not empty at reset vector after reset");

  // Fetch address only moves on a phase one edge
  chk_fetch_addr_hold: assert property ( // RULE2
    phase != PH_ONE || !clkEn |=> $stable(fetch.addr))
    else $error("fetch address moved outside phase one");

  // Holding register stands for the whole execution cycle
  chk_ir_hold_cycle: assert property ( // RULE3
    phase != PH_ONE || !clkEn |=> $stable(instrHold) && $stable(instrValid))
    else $error("holding register changed outside phase one");

  // A filled fetch slot becomes a valid instruction at the next phase one
  chk_valid_after_fill: assert property ( // RULE5
    clkEn && phase == PH_FOUR && !(instrValid && branch.req) ##1 (clkEn && phase == PH_ONE) |=> instrValid)
    else $error("plain instruction did not retire in one cycle");

  // Page bit of a taken branch comes from the status page input
  chk_page_bit_target: assert property ( // RULE15
    clkEn && phase == PH_FOUR && instrValid && branch.req
      |=> s_q.pc[PAGE_BIT_POS] == $past(pageSel) && s_q.pc[PC_W-1] == 1'b0)
    else $error("branch page bit not taken from page select");

  // Low offsets of the file are flagged as special function registers
  chk_sfr_flag: assert property ( // RULE13
    clkEn && phase == PH_ONE |=> dmem.special_function_register == ($past(s_q.fetched[4:0]) <= SFR_LAST_OFF))
    else $error("special function flag wrong");

  // Shared words fold back into bank zero whatever the pointer says
  chk_shared_fold: assert property ( // RULE16
    clkEn && phase == PH_ONE && s_q.fetched[4:0] >= SHARED_FIRST && s_q.fetched[4:0] <= SHARED_LAST
      |=> dmem.addr[6:5] == 2'b00)
    else $error("shared offset not folded to bank zero");

  // Fetches in user space are flagged as user and writable
  chk_region_user_map: assert property ( // RULE8
    fetch.addr <= USER_LAST |-> fetch.region == RG_USER && fetch.writable)
    else $error("user address decoded to wrong region");

  // Region decoder at the edges of the data flash block
  chk_flash_data_map: assert property ( // RULE9
    regionOf(FLASH_DATA_FIRST) == RG_FLASH_DATA && regionOf(FLASH_DATA_LAST) == RG_FLASH_DATA)
    else $error("data flash block decoded wrong");

  // Region decoder at the edges of the identification words
  chk_user_id_map: assert property ( // RULE11
    regionOf(CFG_FIRST) == RG_USER_ID && regionOf(USER_ID_LAST) == RG_USER_ID)
    else $error("identification words decoded wrong");

  // Region decoder at the edges of the calibration backups
  chk_cal_backup_map: assert property ( // RULE11
    regionOf(CAL_FIRST) == RG_CAL_BACKUP && regionOf(CAL_LAST) == RG_CAL_BACKUP)
    else $error("calibration backups decoded wrong");

  // Region decoder at the edges of the reserved block
  chk_reserved_map: assert property ( // RULE12
    regionOf(RSV_FIRST) == RG_RESERVED && regionOf(RSV_LAST) == RG_RESERVED)
    else $error("reserved block decoded wrong");

  // Configuration word and the rest of configuration space
  chk_cfg_word_map: assert property ( // RULE10
    regionOf(CFG_WORD_ADDR) == RG_CFG_WORD && regionOf(11'h4a0) == RG_CFG_OTHER)
    else $error("configuration space decoded wrong");

  // Data banks one and three follow the pointer bits at the lowest and highest offsets above the shared words
  chk_bank_base_map: assert property ( // RULE14
    bankMap(8'h20, 5'h10) == BANK1_BASE + 7'h10 && bankMap(8'h60, 5'h1f) == BANK3_BASE + 7'h1f)
    else $error("bank base addresses wrong");

  // A branch in front of an empty slot is refused
  chk_branch_refused: assert property ( // RULE6
    clkEn && phase == PH_FOUR && !instrValid && branch.req |=> s_q.fetchedValid)
    else $error("branch taken while no instruction was valid");

  cov_freeze: cover property (
    !clkEn ##1 !clkEn);

  cov_branch_taken: cover property (
    clkEn && phase == PH_FOUR && instrValid && branch.req);

  cov_back_to_back: cover property (
    instrValid && clkEn && phase == PH_FOUR ##1 clkEn [*4] ##0 instrValid);

  cov_data_write: cover property (
    dmem.wrEn && !dmem.special_function_register);

  cov_high_bank: cover property (
    dmem.rdEn && dmem.addr[6:5] == 2'b11);

endmodule

`default_nettype wire

// ===== qpf_mem_model.sv
// Program memory and data register file model facing the fetch pipeline
`timescale 1ns/1ns
`default_nettype none

module qpf_mem_model (
  input  wire logic                 ref_clk,
  input  wire logic                 slow,
  input  wire qpf_pkg::qpf_fetch_t  fetch,
  input  wire qpf_pkg::qpf_phases_t phases,
  input  wire qpf_pkg::qpf_dmem_t   dmem,
  output logic [11:0]               progData,
  output int                        nWr
);
  import qpf_pkg::*;
  logic [11:0] lastWord_q = 12'h000;

  // Word per address; a slow memory is valid only in phase four, otherwise the bus toggles
  always_comb begin
    if (fetch.rdEn && (!slow || phases.four))
      progData = 12'(fetch.addr * 7 + 12'h0a3);
    else
      progData = ~lastWord_q;
  end

  // Write count starts from zero so the bench can take differences
  initial begin
    nWr = 0;
  end

  // Remember the bus and count destination writes into the file
  always @(posedge ref_clk) begin
    lastWord_q <= progData;
    if (dmem.wrEn)
      nWr <= nWr + 1;
  end
endmodule
`default_nettype wire

// ===== qpf_fetch_pipeline_tb.sv
// Self-checking testbench of the quad phase fetch pipeline
`timescale 1ns/1ns
`default_nettype none

module qpf_fetch_pipeline_tb;
  import qpf_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        clkEn;
  logic        pageSel;
  logic [7:0]  fileSelect;
  qpf_branch_t branch;
  logic        execWrReq;
  logic        slow;
  logic [11:0] progData;
  qpf_fetch_t  fetch;
  logic [11:0] instrHold;
  logic        instrValid;
  qpf_phases_t phases;
  qpf_dmem_t   dmem;
  int          nWr;
  int          numErrors;
  int          nCompared;
  int          cycles;
  logic        mon;
  logic        prevEn;
  qpf_phases_t prevPh;

  qpf_fetch_pipeline i_dut (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .progData(progData),
    .pageSel(pageSel), .fileSelect(fileSelect), .branch(branch),
    .execWrReq(execWrReq), .fetch(fetch), .instrHold(instrHold),
    .instrValid(instrValid), .phases(phases), .dmem(dmem)
  );
  qpf_mem_model i_mem (
    .ref_clk(ref_clk), .slow(slow), .fetch(fetch), .phases(phases),
    .dmem(dmem), .progData(progData), .nWr(nWr)
  );

  // Free running clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Expected word at a program address
  function automatic logic [11:0] wordAt(input logic [10:0] a);
    return 12'({1'b0, a} * 12'd7 + 12'h0a3);
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step;
    @(negedge ref_clk);
  endtask

  // Move to the settled middle of the next cycle in phase p
  task automatic toPhase(input int p);
    int k;
    k = 0;
    step;
    while (phases[4-p] !== 1'b1 && k < 8) begin
      step;
      k++;
    end
    cmp(phases[4-p], 1'b1);
  endtask

  task automatic giveVerdict;
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Per cycle watch of phase rotation and strobe timing
  always @(negedge ref_clk) begin
    if (mon && !rst) begin
      cmp($onehot(phases), 1'b1);
      cmp(phases, prevEn ? {prevPh[0], prevPh[3:1]} : prevPh);
      cmp(fetch.rdEn, !phases.one);
      cmp(dmem.rdEn, clkEn & phases.two & instrValid);
      cmp(dmem.wrEn, clkEn & phases.four & instrValid & execWrReq);
    end
    prevPh <= phases;
    prevEn <= clkEn;
  end

  // Cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      giveVerdict;
    end
  end

  task automatic doReset;
    @(posedge ref_clk);
    rst <= 1'b1;
    mon <= 1'b0;
    repeat (5) @(posedge ref_clk);
    cmp(fetch.addr, RESET_VECTOR);
    cmp({instrValid, fetch.rdEn, phases}, 6'h08);
    rst <= 1'b0;
    step;
    @(posedge ref_clk);
    mon <= 1'b1;
  endtask

  task automatic testFirst;
    toPhase(2);
    cmp(instrValid, 1'b0);
    for (int k = 0; k < 4; k++) begin
      repeat (4) step;
      cmp(instrValid, 1'b1);
      cmp(instrHold, wordAt(k == 0 ? RESET_VECTOR : 11'(k - 1)));
      cmp(fetch.addr, 11'(k));
      cmp({fetch.region, fetch.writable}, {RG_USER, 1'b1});
    end
    $display("test first fetch done");
  endtask

  task automatic doBranch(input logic pg, input logic [8:0] tgt);
    toPhase(3);
    @(posedge ref_clk);
    branch <= '{req: 1'b1, target: tgt};
    pageSel <= pg;
    @(posedge ref_clk);
    branch.req <= 1'b0;
  endtask

  task automatic testBranch;
    doBranch(1'b1, 9'h1a5);
    toPhase(2);
    cmp({instrValid, 1'b0, fetch.addr}, 13'h03a5);
    doBranch(1'b0, 9'h011);
    toPhase(2);
    cmp({instrValid, instrHold}, {1'b1, wordAt(11'h3a5)});
    cmp(fetch.addr, 11'h3a6);
    doBranch(1'b0, 9'h0a0);
    toPhase(2);
    cmp({instrValid, 1'b0, fetch.addr}, 13'h00a0);
    $display("test branch done");
  endtask

  task automatic testBanks;
    logic [11:0] w;
    logic [4:0]  off;
    for (int b = 0; b < 8; b++) begin
      toPhase(3);
      @(posedge ref_clk);
      fileSelect <= {1'b1, 2'(b), 5'h15};
      toPhase(2);
      w = wordAt(11'(11'h0a0 + b));
      off = w[4:0];
      cmp(instrHold, w);
      cmp(dmem.addr, (off >= SHARED_FIRST && off <= SHARED_LAST) ? {2'h0, off} : {2'(b), off});
      cmp(dmem.special_function_register, off <= SFR_LAST_OFF);
    end
    $display("test banks done");
  endtask

  task automatic testWrite;
    int n0;
    n0 = nWr;
    toPhase(1);
    @(posedge ref_clk);
    execWrReq <= 1'b1;
    toPhase(1);
    @(posedge ref_clk);
    execWrReq <= 1'b0;
    cmp(16'(nWr - n0), 16'h0001);
    $display("test write done");
  endtask

  task automatic testFreeze;
    logic [10:0] a;
    toPhase(2);
    @(posedge ref_clk);
    clkEn <= 1'b0;
    step;
    a = fetch.addr;
    repeat (3) step;
    cmp({phases, 1'b0, fetch.addr}, {4'h2, 1'b0, a});
    @(posedge ref_clk);
    clkEn <= 1'b1;
    $display("test freeze done");
  endtask

  // Main sequence, with a slow memory after the second reset
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    pageSel = 1'b0;
    fileSelect = 8'h00;
    branch = '0;
    execWrReq = 1'b0;
    slow = 1'b0;
    mon = 1'b0;
    doReset;
    testFirst;
    testBranch;
    testBanks;
    testWrite;
    testFreeze;
    slow <= 1'b1;
    doReset;
    testFirst;
    giveVerdict;
  end
endmodule
`default_nettype wire
